// [core/rlc_defines.svh]
// Purpose: Offsets, field positions, reset values and timing figures of the radio link register bank
// Assumes: 20 MHz system clock; registers sit at their printed byte offsets on a 7-bit address
// Notes:   Definitions only; included by the wake timer, register bank, host model and bench
`ifndef RLC_DEFINES_SVH
`define RLC_DEFINES_SVH

// ==========================================================================
// Register offsets
`define RLC_ADDR_W               7
`define RLC_ADDR_GW_RADIO        7'h08
`define RLC_ADDR_GW_TEST         7'h10
`define RLC_ADDR_NODE_RADIO      7'h58
`define RLC_ADDR_NODE_MODE       7'h5C
`define RLC_ADDR_WAKE_COUNT      7'h5E
`define RLC_ADDR_WAKE_SCALE      7'h60

// ==========================================================================
// Reset values
`define RLC_RST_RADIO            16'h0008
`define RLC_RST_GW_TEST          16'h0000
`define RLC_RST_NODE_MODE        16'h0000
`define RLC_RST_WAKE_COUNT       16'h0FA0
`define RLC_RST_WAKE_SCALE       16'h0001

// ==========================================================================
// Writable bit masks (don't-care bits are dropped and read as zero)
`define RLC_MASK_RADIO           16'h3F1F
`define RLC_MASK_GW_TEST         16'h0C00
`define RLC_MASK_NODE_MODE       16'h0C42
`define RLC_MASK_WAKE_SCALE      16'h0003

// ==========================================================================
// Field positions
`define RLC_CHAN_MSB             13
`define RLC_CHAN_LSB             8
`define RLC_PWR_MSB              4
`define RLC_PWR_LSB              0
`define RLC_BIT_CONT_TX          11
`define RLC_BIT_CONT_HOP         10
`define RLC_BIT_HOP_EN           6
`define RLC_BIT_ALARM_ONLY       1
`define RLC_CHAN_MAX             6'h32
`define RLC_PWR_MAX              5'h0F

// ==========================================================================
// Timing: clock period and interval units, all in ns
`define RLC_CLK_PERIOD_NS        50
`define RLC_UNIT_30US_NS         30520
`define RLC_UNIT_488US_NS        488000
`define RLC_UNIT_1_128S_NS       7812500
`define RLC_UNIT_1S_NS           1000000000

`endif

// [core/rlc_pkg.sv]
// Purpose: Types shared by the radio link register bank
// Assumes: Constants come from rlc_defines.svh
// Notes:   Types only
package rlc_pkg;

    // ======================================================================
    // Interval time unit selection
    typedef enum logic [1:0] {
        RLC_SCALE_30US   = 2'h0,
        RLC_SCALE_488US  = 2'h1,
        RLC_SCALE_1_128S = 2'h2,
        RLC_SCALE_1S     = 2'h3
    } rlc_scale_e;

    // ======================================================================
    // Register data word
    typedef logic [15:0] rlc_word_t;

endpackage : rlc_pkg

// [core/rlc_timer_if.sv]
// Purpose: Carries interval settings to the wake timer and its pulse back
// Assumes: Single clock domain
// Notes:   ctrl side is the register bank, timer side the down-counter
`timescale 1ns/100ps
interface rlc_timer_if;
    import rlc_pkg::*;
    rlc_word_t  interval_count;
    rlc_scale_e scale;
    logic       restart;
    logic       wake;

    modport ctrl  (output interval_count, output scale, output restart, input wake);
    modport timer (input interval_count, input scale, input restart, output wake);
endinterface : rlc_timer_if

// [core/rlc_wake_timer.sv]
// Purpose: Wake interval down-counter ticked at the selected time unit
// Assumes: Settings stable except when restart pulses
// Notes:   An interval of zero behaves as one unit
`timescale 1ns/100ps
`include "rlc_defines.svh"
module rlc_wake_timer
    import rlc_pkg::*;
#(
    parameter int unsigned P_TICK_30US   = 610,
    parameter int unsigned P_TICK_488US  = 9760,
    parameter int unsigned P_TICK_1_128S = 156250,
    parameter int unsigned P_TICK_1S     = 20000000
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    // Settings and wake pulse
    rlc_timer_if.timer tmr
);

    // ======================================================================
    // Unit length in cycles
    function automatic logic [31:0] unit_len(input rlc_scale_e s);
        case (s)
            RLC_SCALE_30US:   unit_len = 32'(P_TICK_30US);
            RLC_SCALE_488US:  unit_len = 32'(P_TICK_488US);
            RLC_SCALE_1_128S: unit_len = 32'(P_TICK_1_128S);
            default:          unit_len = 32'(P_TICK_1S);
        endcase
    endfunction : unit_len

    logic [31:0] presc_q;
    logic [15:0] cnt_q;
    logic        wake_q;
    logic [31:0] len_w;
    logic        tick_w;
    logic        expire_w;

    assign len_w    = unit_len(tmr.scale);
    assign tick_w   = (presc_q >= (len_w - 32'h1));
    assign expire_w = tick_w && (cnt_q <= 16'h1);

    // Prescaler producing one tick per time unit
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            presc_q <= 32'h0;
        end else if (tmr.restart || tick_w) begin
            presc_q <= 32'h0;
        end else begin
            presc_q <= presc_q + 32'h1;
        end
    end

    // Down-counter reloading from the interval count
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= `RLC_RST_WAKE_COUNT;
        end else if (tmr.restart || expire_w) begin
            cnt_q <= tmr.interval_count;
        end else if (tick_w) begin
            cnt_q <= cnt_q - 16'h1;
        end
    end

    // Single-cycle wake pulse on expiry
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= expire_w && !tmr.restart;
        end
    end

    assign tmr.wake = wake_q;

    // ======================================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_wake_single_cycle: assert property (wake_q |=> !wake_q)
        else $error("wake pulse longer than one cycle");
    a_wake_reloads_count: assert property (wake_q && !$past(tmr.restart) |-> cnt_q == $past(tmr.interval_count))
        else $error("counter not reloaded at wake");
    a_tick_unit_length: assert property (tick_w && !tmr.restart |=> presc_q == 32'h0)
        else $error("prescaler not restarted at tick");
    a_restart_loads: assert property (tmr.restart |=> cnt_q == $past(tmr.interval_count) && !wake_q)
        else $error("restart did not load interval");
    c_wake_seen: cover property (wake_q);
endmodule : rlc_wake_timer

// [core/rlc_regs.sv]
// Purpose: Radio link configuration register bank with wake interval pacing
// Assumes: Host accesses arrive already decoded from the serial port, one per cycle
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/100ps
`include "rlc_defines.svh"
module rlc_regs
    import rlc_pkg::*;
#(
    parameter int unsigned P_TICK_30US   = `RLC_UNIT_30US_NS / `RLC_CLK_PERIOD_NS,
    parameter int unsigned P_TICK_488US  = `RLC_UNIT_488US_NS / `RLC_CLK_PERIOD_NS,
    parameter int unsigned P_TICK_1_128S = `RLC_UNIT_1_128S_NS / `RLC_CLK_PERIOD_NS,
    parameter int unsigned P_TICK_1S     = `RLC_UNIT_1S_NS / `RLC_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_b_i,
    // Host register port
    input  wire logic                   wr_en_i,
    input  wire logic                   rd_en_i,
    input  wire logic [`RLC_ADDR_W-1:0] addr_i,
    input  wire logic [15:0]            wr_data_i,
    output logic      [15:0]            rd_data_o,
    output logic                        rd_valid_o,
    // Gateway radio controls
    output logic      [5:0]             gw_channel_o,
    output logic      [4:0]             gw_power_o,
    output logic                        gw_cont_tx_o,
    output logic                        gw_cont_hop_o,
    // Node radio controls
    output logic      [5:0]             node_channel_o,
    output logic      [4:0]             node_power_o,
    output logic                        node_cont_tx_o,
    output logic                        node_cont_hop_o,
    output logic                        node_hop_en_o,
    output logic                        node_alarm_only_o,
    // Wake pacing
    output logic                        wake_o
);

    // ======================================================================
    // Storage
    rlc_word_t  gw_radio_q;
    rlc_word_t  gw_test_q;
    rlc_word_t  node_radio_q;
    rlc_word_t  node_mode_q;
    rlc_word_t  wake_count_q;
    rlc_word_t  wake_scale_q;
    rlc_word_t  rd_data_q;
    logic       rd_valid_q;
    logic       restart_q;

    rlc_timer_if tmr_if ();

    // Write strobe for one address
    function automatic logic hit(input logic [`RLC_ADDR_W-1:0] a, input logic [`RLC_ADDR_W-1:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // Read multiplexer; unmapped offsets answer zero
    function automatic rlc_word_t read_mux(input logic [`RLC_ADDR_W-1:0] a);
        case (a)
            `RLC_ADDR_GW_RADIO:   read_mux = gw_radio_q;
            `RLC_ADDR_GW_TEST:    read_mux = gw_test_q;
            `RLC_ADDR_NODE_RADIO: read_mux = node_radio_q;
            `RLC_ADDR_NODE_MODE:  read_mux = node_mode_q;
            `RLC_ADDR_WAKE_COUNT: read_mux = wake_count_q;
            `RLC_ADDR_WAKE_SCALE: read_mux = wake_scale_q;
            default:              read_mux = 16'h0000;
        endcase
    endfunction : read_mux

    // ======================================================================
    // Gateway radio settings and test mode
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gw_radio_q <= `RLC_RST_RADIO;
            gw_test_q  <= `RLC_RST_GW_TEST;
        end else if (wr_en_i) begin
            if (hit(addr_i, `RLC_ADDR_GW_RADIO)) begin
                gw_radio_q <= wr_data_i & `RLC_MASK_RADIO;
            end
            if (hit(addr_i, `RLC_ADDR_GW_TEST)) begin
                gw_test_q <= wr_data_i & `RLC_MASK_GW_TEST;
            end
        end
    end

    // ======================================================================
    // Node radio settings and link mode
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            node_radio_q <= `RLC_RST_RADIO;
            node_mode_q  <= `RLC_RST_NODE_MODE;
        end else if (wr_en_i) begin
            if (hit(addr_i, `RLC_ADDR_NODE_RADIO)) begin
                node_radio_q <= wr_data_i & `RLC_MASK_RADIO;
            end
            if (hit(addr_i, `RLC_ADDR_NODE_MODE)) begin
                node_mode_q <= wr_data_i & `RLC_MASK_NODE_MODE;
            end
        end
    end

    // ======================================================================
    // Wake interval settings; a write restarts the timer next cycle
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_count_q <= `RLC_RST_WAKE_COUNT;
            wake_scale_q <= `RLC_RST_WAKE_SCALE;
            restart_q    <= 1'b0;
        end else begin
            restart_q <= wr_en_i && (hit(addr_i, `RLC_ADDR_WAKE_COUNT) || hit(addr_i, `RLC_ADDR_WAKE_SCALE));
            if (wr_en_i && hit(addr_i, `RLC_ADDR_WAKE_COUNT)) begin
                wake_count_q <= wr_data_i;
            end
            if (wr_en_i && hit(addr_i, `RLC_ADDR_WAKE_SCALE)) begin
                wake_scale_q <= wr_data_i & `RLC_MASK_WAKE_SCALE;
            end
        end
    end

    // ======================================================================
    // Read path, one cycle latency
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_en_i;
            if (rd_en_i) begin
                rd_data_q <= read_mux(addr_i);
            end
        end
    end

    // ======================================================================
    // Wake timer
    assign tmr_if.interval_count = wake_count_q;
    assign tmr_if.scale          = rlc_scale_e'(wake_scale_q[1:0]);
    assign tmr_if.restart        = restart_q;

    rlc_wake_timer #(
        .P_TICK_30US   (P_TICK_30US),
        .P_TICK_488US  (P_TICK_488US),
        .P_TICK_1_128S (P_TICK_1_128S),
        .P_TICK_1S     (P_TICK_1S)
    ) u_wake_timer (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .tmr       (tmr_if.timer)
    );

    // ======================================================================
    // Outputs, all taken from register flops
    assign rd_data_o         = rd_data_q;
    assign rd_valid_o        = rd_valid_q;
    assign gw_channel_o      = gw_radio_q[`RLC_CHAN_MSB:`RLC_CHAN_LSB];
    assign gw_power_o        = gw_radio_q[`RLC_PWR_MSB:`RLC_PWR_LSB];
    assign gw_cont_tx_o      = gw_test_q[`RLC_BIT_CONT_TX];
    assign gw_cont_hop_o     = gw_test_q[`RLC_BIT_CONT_HOP];
    assign node_channel_o    = node_radio_q[`RLC_CHAN_MSB:`RLC_CHAN_LSB];
    assign node_power_o      = node_radio_q[`RLC_PWR_MSB:`RLC_PWR_LSB];
    assign node_cont_tx_o    = node_mode_q[`RLC_BIT_CONT_TX];
    assign node_cont_hop_o   = node_mode_q[`RLC_BIT_CONT_HOP];
    assign node_hop_en_o     = node_mode_q[`RLC_BIT_HOP_EN];
    assign node_alarm_only_o = node_mode_q[`RLC_BIT_ALARM_ONLY];
    assign wake_o            = tmr_if.wake;

    // ======================================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_radio_channel_field: assert property (wr_en_i && addr_i == `RLC_ADDR_GW_RADIO |=> gw_channel_o == $past(wr_data_i[13:8]))
        else $error("gateway channel not taken from bits 13:8");
    a_radio_power_field: assert property (wr_en_i && addr_i == `RLC_ADDR_NODE_RADIO |=> node_power_o == $past(wr_data_i[4:0]))
        else $error("node power not taken from bits 4:0");
    a_radio_dont_care: assert property (rd_valid_o && $past(addr_i) == `RLC_ADDR_NODE_RADIO |-> rd_data_o[15:14] == 2'h0 && rd_data_o[7:5] == 3'h0)
        else $error("radio don't-care bits read back nonzero");
    a_node_cont_tx: assert property (wr_en_i && addr_i == `RLC_ADDR_NODE_MODE |=> node_cont_tx_o == $past(wr_data_i[11]))
        else $error("continuous transmit not following bit 11");
    a_node_cont_hop: assert property (wr_en_i && addr_i == `RLC_ADDR_NODE_MODE |=> node_cont_hop_o == $past(wr_data_i[10]))
        else $error("continuous hopping not following bit 10");
    a_node_hop_en: assert property (wr_en_i && addr_i == `RLC_ADDR_NODE_MODE |=> node_hop_en_o == $past(wr_data_i[6]))
        else $error("hopping enable not following bit 6");
    a_node_alarm_only: assert property (wr_en_i && addr_i == `RLC_ADDR_NODE_MODE |=> node_alarm_only_o == $past(wr_data_i[1]))
        else $error("alarm-only not following bit 1");
    a_mode_unused_zero: assert property (rd_valid_o && $past(addr_i) == `RLC_ADDR_NODE_MODE |-> (rd_data_o & 16'hF3BD) == 16'h0)
        else $error("unused link mode bits read back nonzero");
    a_scale_restart: assert property (wr_en_i && addr_i == `RLC_ADDR_WAKE_SCALE |=> restart_q ##1 !wake_o)
        else $error("scale write did not restart timer");
    a_gw_test_bits: assert property (wr_en_i && addr_i == `RLC_ADDR_GW_TEST |=> gw_cont_tx_o == $past(wr_data_i[11]) && gw_cont_hop_o == $past(wr_data_i[10]))
        else $error("gateway test bits not following write");
    a_unmapped_zero: assert property (rd_en_i && !(addr_i inside {`RLC_ADDR_GW_RADIO, `RLC_ADDR_GW_TEST, `RLC_ADDR_NODE_RADIO, `RLC_ADDR_NODE_MODE, `RLC_ADDR_WAKE_COUNT, `RLC_ADDR_WAKE_SCALE}) |=> rd_data_o == 16'h0)
        else $error("unmapped read not zero");

    c_node_cont_tx: cover property (node_cont_tx_o && node_hop_en_o);
    c_wake_pulse: cover property (wake_o);
    c_gw_hop_test: cover property (gw_cont_hop_o);
endmodule : rlc_regs

// [verification/rlc_host_model.sv]
// Purpose: Host processor model driving the decoded register strobes of the bank
// Assumes: Strobes change only by non-blocking assignment at the rising edge
// Notes:   Tasks are called by the testbench; released address and data show inverted values
`timescale 1ns/100ps
`include "rlc_defines.svh"
module rlc_host_model
    import rlc_pkg::*;
(
    // Clock
    input  wire logic                   sys_clk_i,
    // Register port towards the device
    output logic                        wr_en_o,
    output logic                        rd_en_o,
    output logic      [`RLC_ADDR_W-1:0] addr_o,
    output logic      [15:0]            wr_data_o,
    input  wire logic [15:0]            rd_data_i,
    input  wire logic                   rd_valid_i
);
    // ======================================================================
    // Idle levels at time zero
    initial begin
        wr_en_o   = 1'b0;
        rd_en_o   = 1'b0;
        addr_o    = 7'h7F;
        wr_data_o = 16'hFFFF;
    end

    // One access; both strobes are held for exactly one sampling edge
    task automatic access(input logic w, input logic r, input logic [6:0] a, input rlc_word_t d,
                          output rlc_word_t q, output logic v);
        @(posedge sys_clk_i);
        wr_en_o   <= w;
        rd_en_o   <= r;
        addr_o    <= a;
        wr_data_o <= d;
        @(posedge sys_clk_i);
        wr_en_o   <= 1'b0;
        rd_en_o   <= 1'b0;
        addr_o    <= ~a;
        wr_data_o <= ~d;
        #1;
        q = rd_data_i;
        v = rd_valid_i;
    endtask : access

    // Power above -1 dBm (index 8) only with hopping enabled
    task automatic set_node_power(input logic [4:0] p, input logic hop);
        rlc_word_t q;
        logic      v;
        access(1'b1, 1'b0, `RLC_ADDR_NODE_MODE, hop ? 16'h0040 : 16'h0000, q, v);
        access(1'b1, 1'b0, `RLC_ADDR_NODE_RADIO, {11'h000, (hop || p <= 5'h08) ? p : 5'h08}, q, v);
    endtask : set_node_power
endmodule : rlc_host_model

// [verification/rlc_regs_tb.sv]
// Purpose: Self-checking bench for the radio link register bank and wake pacing
// Assumes: Shortened interval units of 3, 4, 5 and 6 cycles
// Notes:   Expected values are worked out from the field layout, not read from the design
`timescale 1ns/100ps
`include "rlc_defines.svh"
module rlc_regs_tb;
    localparam int unsigned T_30  = 3;
    localparam int unsigned T_488 = 4;
    localparam int unsigned T_128 = 5;
    localparam int unsigned T_1S  = 6;

    logic        sys_clk_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        wr_en, rd_en, rd_valid, wake_o, rd_v;
    logic [6:0]  addr;
    logic [15:0] wr_data, rd_data, rd_d, gw_vec, node_vec;
    logic [5:0]  gw_ch, nd_ch;
    logic [4:0]  gw_pw, nd_pw;
    logic        gw_tx, gw_hop, nd_tx, nd_chop, nd_hop, nd_alarm;
    int          err_total = 0;
    int          n_checks  = 0;
    int          cyc, nl;
    int          unit_len [4] = '{T_30, T_488, T_128, T_1S};
    int          mode_bit [4] = '{11, 10, 6, 1};
    logic [6:0]  t_addr [7] = '{`RLC_ADDR_GW_RADIO, `RLC_ADDR_NODE_RADIO, `RLC_ADDR_NODE_MODE,
                                `RLC_ADDR_GW_TEST, `RLC_ADDR_WAKE_SCALE, `RLC_ADDR_WAKE_COUNT, 7'h02};
    logic [15:0] t_rst  [7] = '{16'h0008, 16'h0008, 16'h0000, 16'h0000, 16'h0001, 16'h0FA0, 16'h0000};
    logic [15:0] t_mask [7] = '{16'h3F1F, 16'h3F1F, 16'h0C42, 16'h0C00, 16'h0003, 16'hFFFF, 16'h0000};

    // Field outputs gathered into one word per radio
    assign gw_vec   = {3'h0, gw_tx, gw_hop, gw_ch, gw_pw};
    assign node_vec = {1'h0, nd_tx, nd_chop, nd_hop, nd_alarm, nd_ch, nd_pw};

    // 20 MHz clock
    always #25 sys_clk_i = ~sys_clk_i;

    // ======================================================================
    // Design and host
    rlc_regs #(.P_TICK_30US(T_30), .P_TICK_488US(T_488), .P_TICK_1_128S(T_128), .P_TICK_1S(T_1S)) DUT (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
        .wr_data_i(wr_data), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .gw_channel_o(gw_ch),
        .gw_power_o(gw_pw), .gw_cont_tx_o(gw_tx), .gw_cont_hop_o(gw_hop), .node_channel_o(nd_ch),
        .node_power_o(nd_pw), .node_cont_tx_o(nd_tx), .node_cont_hop_o(nd_chop), .node_hop_en_o(nd_hop),
        .node_alarm_only_o(nd_alarm), .wake_o(wake_o));
    rlc_host_model host (.sys_clk_i(sys_clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
        .wr_data_o(wr_data), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

    // ======================================================================
    // Compare, access and closing tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.access(1'b1, 1'b0, a, d, rd_d, rd_v);
    endtask : wr
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
        host.access(1'b0, 1'b1, a, 16'h0000, rd_d, rd_v);
        chk("read valid", 16'h0001, {15'h0000, rd_v});
        chk("read data", exp, rd_d);
    endtask : rd_chk
    task automatic wait_wake(output int n);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end while (wake_o !== 1'b1 && n < 100);
    endtask : wait_wake
    task automatic stop_test;
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // Watchdog well beyond the expected run of about 250 cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        $display("BAD watchdog expected finish seen timeout");
        stop_test();
    end

    // ======================================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        chk("gw fields at reset", 16'h0008, gw_vec);
        for (int i = 0; i < 7; i++) begin
            rd_chk(t_addr[i], t_rst[i]);
            wr(t_addr[i], 16'hFFFF);
            rd_chk(t_addr[i], t_mask[i]);
        end
        chk("gw fields all ones", 16'h1FFF, gw_vec);
        chk("node fields all ones", 16'h7FFF, node_vec);
        for (int i = 0; i < 7; i++) wr(t_addr[i], 16'h0000);
        wr(`RLC_ADDR_GW_RADIO, 16'h320F);
        chk("gw channel 50 power 15", 16'h064F, gw_vec);
        wr(`RLC_ADDR_NODE_RADIO, 16'hC033);
        chk("node channel 0 power 19", 16'h0013, node_vec);
        for (int k = 0; k < 4; k++) begin
            wr(`RLC_ADDR_NODE_MODE, 16'h0001 << mode_bit[k]);
            chk("node mode outputs", 16'h4000 >> k, {node_vec[15:11], 11'h000});
        end
        for (int k = 0; k < 2; k++) begin
            wr(`RLC_ADDR_GW_TEST, 16'h0800 >> k);
            chk("gw test outputs", 16'h1000 >> k, {gw_vec[15:11], 11'h000});
        end
        host.access(1'b1, 1'b1, `RLC_ADDR_GW_RADIO, 16'h0105, rd_d, rd_v);
        chk("read beside write", 16'h320F, rd_d);
        rd_chk(`RLC_ADDR_GW_RADIO, 16'h0105);
        host.set_node_power(5'h0F, 1'b0);
        chk("node power capped", 16'h0008, {11'h000, nd_pw});
        host.set_node_power(5'h0F, 1'b1);
        chk("node power with hopping", 16'h100F, {node_vec[15:11], 6'h00, nd_pw});
        // Wake delay and period for every unit, then a count of zero
        for (int s = 0; s < 5; s++) begin
            nl = (s == 4) ? T_488 : 3 * unit_len[s];
            wr(`RLC_ADDR_WAKE_SCALE, (s == 4) ? 16'h0001 : 16'(s));
            wr(`RLC_ADDR_WAKE_COUNT, (s == 4) ? 16'h0000 : 16'h0003);
            wait_wake(cyc);
            chk("wake delay", 16'(nl + 1), 16'(cyc));
            wait_wake(cyc);
            chk("wake period", 16'(nl), 16'(cyc));
        end
        // Reset in mid-run brings the defaults back
        @(posedge sys_clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd_chk(`RLC_ADDR_WAKE_COUNT, 16'h0FA0);
        rd_chk(`RLC_ADDR_NODE_MODE, 16'h0000);
        chk("gw fields after reset", 16'h0008, gw_vec);
        stop_test();
    end
endmodule : rlc_regs_tb
